// File: verilog/pocr_regs.sv
// Behaviour
// RL1 - downstream status write of 4 wakes next module's first zone.
// RL2 - downstream status write of 1 signals carton exit, tracking adopted on arrival.
// RL3 - upstream status write of 5 makes upstream discharge zone accumulate.
// RL4 - upstream status write of 1 makes upstream discharge zone release.
// RL5 - tracking words travel downstream only together with the downstream status.
// RL6 - mask bits 0,2,4,6 map left aux, right aux, left signal, right signal.
// RL7 - logical input equals electrical level xor mask bit.
// RL8 - green indicator lit exactly when conditioned input bit is one.
// RL9 - entering PLC mode clears mask loaded by auto configuration.
// RL10 - PLC writes mask before trusting conditioned inputs.
// RL11 - servo target is signed millimetres within -32767..+32767.
// RL12 - servo target is absolute from zero point.
// RL13 - command bit 0 set loads present distance count as zero; the sequencer ignores the bit while in SV_MOVE.
// RL14 - command bit 1 set moves motor from present count to target.
// RL15 - move end raises done; done clears once run bit seen low.
// RL16 - PLC holds zero bit until zero acknowledge, then clears it.
// RL17 - servo direction ignores configuration; positive is counter-clockwise.
// RL18 - every word is 16 bits; reserved bits and word ignore writes.
`timescale 1ns/1ns
module pocr_regs (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // word write and read port
    input  wire logic                  wr_en,
    input  wire logic [11:0]           wr_addr,
    input  wire logic [15:0]           wr_data,
    input  wire logic                  rd_en,
    input  wire logic [11:0]           rd_addr,
    output logic [15:0]                rd_data,
    // operating mode and auto configuration
    input  wire logic                  plc_mode,
    input  wire logic                  autocfg_load,
    input  wire logic [15:0]           autocfg_mask,
    // sensor pins as raw electrical levels, conditioned inputs and indicators
    input  wire logic [3:0]            sense_pins,
    output logic [3:0]                 sense_logic,
    output logic [3:0]                 sense_led_green,
    // neighbour links
    output pocr_pkg::pocr_ds_msg_t     ds_msg,
    output logic                       ds_wake,
    output logic                       ds_carton_exit,
    output logic                       us_stb,
    output logic [15:0]                us_status,
    output logic                       us_accumulate,
    output logic                       us_release,
    // motor feedback and servo state
    input  wire logic [1:0]            motor_tick,
    output pocr_pkg::pocr_sv_stat_t    left_stat,
    output pocr_pkg::pocr_sv_stat_t    right_stat,
    output logic signed [15:0]         left_pos,
    output logic signed [15:0]         right_pos
);
    import pocr_pkg::*;

    logic [15:0]   ds_stat_q, ds_stat_d;
    logic [15:0]   us_stat_q, us_stat_d;
    logic [15:0]   mask_q, mask_d;
    logic [15:0]   trk1_q, trk1_d;
    logic [15:0]   trk2_q, trk2_d;
    logic [15:0]   ltgt_q, ltgt_d;
    logic [15:0]   lcmd_q, lcmd_d;
    logic [15:0]   rtgt_q, rtgt_d;
    logic [15:0]   rcmd_q, rcmd_d;
    logic          plc_q;
    logic [15:0]   rd_q, rd_d;
    pocr_ds_msg_t  dsm_q, dsm_d;
    logic          wake_q, wake_d;
    logic          exit_q, exit_d;
    logic          us_stb_q, us_stb_d;
    logic [15:0]   us_out_q, us_out_d;
    logic          acc_q, acc_d;
    logic          rel_q, rel_d;
    logic [3:0]    pin_s1_q, pin_s2_q;
    logic [1:0]    tk_s1_q, tk_s2_q, tk_s3_q;
    logic [3:0]    cond_q, cond_d;
    logic [3:0]    mask_sel;
    logic [1:0]    tick_pulse;

    // register bank next values
    always_comb begin
        ds_stat_d = ds_stat_q;
        us_stat_d = us_stat_q;
        mask_d    = mask_q;
        trk1_d    = trk1_q;
        trk2_d    = trk2_q;
        ltgt_d    = ltgt_q;
        lcmd_d    = lcmd_q;
        rtgt_d    = rtgt_q;
        rcmd_d    = rcmd_q;
        if (!plc_mode && autocfg_load)
            mask_d = autocfg_mask & MASK_WRITABLE;
        if (plc_mode && !plc_q)
            mask_d = WORD_RESET;                             // RL9
        if (wr_en) begin
            case (wr_addr)
                ADDR_DS_STATUS: ds_stat_d = wr_data;
                ADDR_US_STATUS: us_stat_d = wr_data;
                ADDR_IN_MASK:   mask_d    = wr_data & MASK_WRITABLE; // RL18
                ADDR_TRACK_ONE: trk1_d    = wr_data;
                ADDR_TRACK_TWO: trk2_d    = wr_data;
                ADDR_L_TARGET:  ltgt_d    = wr_data;         // RL11
                ADDR_L_COMMAND: lcmd_d    = wr_data & CMD_WRITABLE; // RL18
                ADDR_R_TARGET:  rtgt_d    = wr_data;         // RL11
                ADDR_R_COMMAND: rcmd_d    = wr_data & CMD_WRITABLE; // RL18
                default:        ;                            // reserved word ignored
            endcase
        end
    end

    // register bank flip-flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ds_stat_q <= WORD_RESET;
            us_stat_q <= WORD_RESET;
            mask_q    <= WORD_RESET;
            trk1_q    <= WORD_RESET;
            trk2_q    <= WORD_RESET;
            ltgt_q    <= WORD_RESET;
            lcmd_q    <= WORD_RESET;
            rtgt_q    <= WORD_RESET;
            rcmd_q    <= WORD_RESET;
            plc_q     <= 1'b0;
        end else begin
            ds_stat_q <= ds_stat_d;
            us_stat_q <= us_stat_d;
            mask_q    <= mask_d;
            trk1_q    <= trk1_d;
            trk2_q    <= trk2_d;
            ltgt_q    <= ltgt_d;
            lcmd_q    <= lcmd_d;
            rtgt_q    <= rtgt_d;
            rcmd_q    <= rcmd_d;
            plc_q     <= plc_mode;
        end
    end

    // registered read data, one cycle after rd_en
    always_comb begin
        rd_d = rd_q;
        if (rd_en) begin
            case (rd_addr)
                ADDR_DS_STATUS: rd_d = ds_stat_q;
                ADDR_US_STATUS: rd_d = us_stat_q;
                ADDR_IN_MASK:   rd_d = mask_q;
                ADDR_TRACK_ONE: rd_d = trk1_q;
                ADDR_TRACK_TWO: rd_d = trk2_q;
                ADDR_L_TARGET:  rd_d = ltgt_q;
                ADDR_L_COMMAND: rd_d = lcmd_q;
                ADDR_R_TARGET:  rd_d = rtgt_q;
                ADDR_R_COMMAND: rd_d = rcmd_q;
                default:        rd_d = WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n)
            rd_q <= WORD_RESET;
        else
            rd_q <= rd_d;
    end

    // neighbour messages, launched by a status write
    always_comb begin
        dsm_d     = dsm_q;
        dsm_d.stb = 1'b0;
        wake_d    = 1'b0;
        exit_d    = 1'b0;
        us_stb_d  = 1'b0;
        us_out_d  = us_out_q;
        acc_d     = 1'b0;
        rel_d     = 1'b0;
        if (wr_en && wr_addr == ADDR_DS_STATUS) begin
            dsm_d.stb       = 1'b1;
            dsm_d.status    = wr_data;
            dsm_d.track_one = trk1_q;                        // RL5
            dsm_d.track_two = trk2_q;                        // RL5
            wake_d          = (wr_data == DS_CODE_WAKE);     // RL1
            exit_d          = (wr_data == DS_CODE_EXIT);     // RL2
        end
        if (wr_en && wr_addr == ADDR_US_STATUS) begin
            us_stb_d = 1'b1;
            us_out_d = wr_data;
            acc_d    = (wr_data == US_CODE_HOLD);            // RL3
            rel_d    = (wr_data == US_CODE_RELEASE);         // RL4
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dsm_q    <= '0;
            wake_q   <= 1'b0;
            exit_q   <= 1'b0;
            us_stb_q <= 1'b0;
            us_out_q <= WORD_RESET;
            acc_q    <= 1'b0;
            rel_q    <= 1'b0;
        end else begin
            dsm_q    <= dsm_d;
            wake_q   <= wake_d;
            exit_q   <= exit_d;
            us_stb_q <= us_stb_d;
            us_out_q <= us_out_d;
            acc_q    <= acc_d;
            rel_q    <= rel_d;
        end
    end

    // input conditioning: mask bit per pin, xor with synchronised level
    assign mask_sel = {mask_q[MASK_R_SIG], mask_q[MASK_L_SIG],
                       mask_q[MASK_R_AUX], mask_q[MASK_L_AUX]};     // RL6
    always_comb begin
        cond_d = pin_s2_q ^ mask_sel;                        // RL7
    end

    // synchronisers for pins and motor feedback
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            tk_s1_q  <= 2'h0;
            tk_s2_q  <= 2'h0;
            tk_s3_q  <= 2'h0;
            cond_q   <= 4'h0;
        end else begin
            pin_s1_q <= sense_pins;
            pin_s2_q <= pin_s1_q;
            tk_s1_q  <= motor_tick;
            tk_s2_q  <= tk_s1_q;
            tk_s3_q  <= tk_s2_q;
            cond_q   <= cond_d;
        end
    end
    assign tick_pulse = tk_s2_q & ~tk_s3_q;

    // one servo sequencer per motor port
    pocr_servo u_left (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .target   (ltgt_q),
        .zero_cmd (lcmd_q[CMD_ZERO_BIT]),                    // RL13
        .run_cmd  (lcmd_q[CMD_RUN_BIT]),                     // RL14
        .tick     (tick_pulse[0]),
        .stat     (left_stat),
        .pos      (left_pos)
    );
    pocr_servo u_right (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .target   (rtgt_q),
        .zero_cmd (rcmd_q[CMD_ZERO_BIT]),                    // RL13
        .run_cmd  (rcmd_q[CMD_RUN_BIT]),                     // RL14
        .tick     (tick_pulse[1]),
        .stat     (right_stat),
        .pos      (right_pos)
    );

    // outputs
    assign rd_data         = rd_q;
    assign sense_logic     = cond_q;
    assign sense_led_green = cond_q;                         // RL8
    assign ds_msg          = dsm_q;
    assign ds_wake         = wake_q;
    assign ds_carton_exit  = exit_q;
    assign us_stb          = us_stb_q;
    assign us_status       = us_out_q;
    assign us_accumulate   = acc_q;
    assign us_release      = rel_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wake_pulse: assert property (wr_en && wr_addr == ADDR_DS_STATUS && wr_data == 16'h0004 // RL1
                                   |=> ds_wake && ds_msg.stb
                                   ##1 ds_wake == $past(wr_en && wr_addr == ADDR_DS_STATUS
                                                        && wr_data == DS_CODE_WAKE))
        else $error("wake not sent for status 4");
    a_exit_pulse: assert property (wr_en && wr_addr == ADDR_DS_STATUS && wr_data == 16'h0001 // RL2
                                   |=> ds_carton_exit && !ds_wake)
        else $error("carton exit not sent for status 1");
    a_hold_up: assert property (wr_en && wr_addr == ADDR_US_STATUS && wr_data == 16'h0005 // RL3
                                |=> us_accumulate && !us_release && us_stb)
        else $error("accumulate not sent for status 5");
    a_release_up: assert property (wr_en && wr_addr == ADDR_US_STATUS && wr_data == 16'h0001 // RL4
                                   |=> us_release && !us_accumulate)
        else $error("release not sent for status 1");
    a_track_companion: assert property ($changed(ds_msg.track_one) |-> ds_msg.stb) // RL5
        else $error("tracking moved without status");
    a_mask_reserved: assert property ((mask_q & ~16'h0055) == 16'h0000) // RL18
        else $error("reserved mask bit set");
    a_cond_xor: assert property (sense_logic[3] // RL7
                                 == ($past(pin_s2_q[3]) ^ $past(mask_q[MASK_R_SIG])))
        else $error("right signal input not conditioned");
    a_led_match: assert property (sense_led_green == $past(pin_s2_q ^ mask_sel)) // RL8
        else $error("indicator differs from input bit");
    a_mask_clear: assert property ($rose(plc_mode) && !(wr_en && wr_addr == ADDR_IN_MASK) // RL9
                                   |=> mask_q == 16'h0000)
        else $error("mask not cleared on mode entry");
endmodule

// File: verilog/pocr_pkg.sv
package pocr_pkg;

    // register word addresses
    localparam logic [11:0] ADDR_DS_STATUS  = 12'h719;
    localparam logic [11:0] ADDR_US_STATUS  = 12'h71A;
    localparam logic [11:0] ADDR_IN_MASK    = 12'h71B;
    localparam logic [11:0] ADDR_TRACK_ONE  = 12'h71C;
    localparam logic [11:0] ADDR_TRACK_TWO  = 12'h71D;
    localparam logic [11:0] ADDR_RESERVED   = 12'h71E;
    localparam logic [11:0] ADDR_L_TARGET   = 12'h71F;
    localparam logic [11:0] ADDR_L_COMMAND  = 12'h720;
    localparam logic [11:0] ADDR_R_TARGET   = 12'h721;
    localparam logic [11:0] ADDR_R_COMMAND  = 12'h722;

    // status word codes
    localparam logic [15:0] DS_CODE_WAKE    = 16'h0004;
    localparam logic [15:0] DS_CODE_EXIT    = 16'h0001;
    localparam logic [15:0] US_CODE_HOLD    = 16'h0005;
    localparam logic [15:0] US_CODE_RELEASE = 16'h0001;

    // input mask bit positions and writable bits
    localparam int          MASK_L_AUX      = 0;
    localparam int          MASK_R_AUX      = 2;
    localparam int          MASK_L_SIG      = 4;
    localparam int          MASK_R_SIG      = 6;
    localparam logic [15:0] MASK_WRITABLE   = 16'h0055;

    // servo command word fields
    localparam int          CMD_ZERO_BIT    = 0;
    localparam int          CMD_RUN_BIT     = 1;
    localparam logic [15:0] CMD_WRITABLE    = 16'h0003;

    // reset values and target limits
    localparam logic [15:0]        WORD_RESET = 16'h0000;
    localparam logic signed [15:0] TGT_MAX    = 16'sh7FFF;
    localparam logic signed [15:0] TGT_MIN    = -16'sh7FFF;

    // servo sequencer states
    typedef enum logic [2:0] {
        SV_IDLE = 3'b001,
        SV_MOVE = 3'b010,
        SV_DONE = 3'b100
    } pocr_sv_state_t;

    // servo status carried to the user side
    typedef struct packed {
        logic ready;
        logic zero_ack;
        logic moving;
        logic dir_ccw;
    } pocr_sv_stat_t;

    // status word and tracking word pair forwarded to the downstream neighbour
    typedef struct packed {
        logic        stb;
        logic [15:0] status;
        logic [15:0] track_one;
        logic [15:0] track_two;
    } pocr_ds_msg_t;

    // keep a target inside the legal signed range
    function automatic logic signed [15:0] pocr_clamp(input logic signed [15:0] v);
        pocr_clamp = (v < TGT_MIN) ? TGT_MIN : v;
    endfunction

endpackage

// File: verilog/pocr_servo.sv
`timescale 1ns/1ns
module pocr_servo (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // command side
    input  wire logic signed [15:0]    target,
    input  wire logic                  zero_cmd,
    input  wire logic                  run_cmd,
    input  wire logic                  tick,
    // state
    output pocr_pkg::pocr_sv_stat_t    stat,
    output logic signed [15:0]         pos
);
    import pocr_pkg::*;

    pocr_sv_state_t     st_q, st_d;
    logic signed [15:0] pos_q, pos_d;
    logic signed [15:0] tgt_q, tgt_d;
    logic               zack_q, zack_d;
    logic               ccw_q, ccw_d;

    // sequencer next state
    always_comb begin
        st_d   = st_q;
        pos_d  = pos_q;
        tgt_d  = tgt_q;
        zack_d = zack_q;
        ccw_d  = ccw_q;
        if (zero_cmd && st_q != SV_MOVE) begin
            pos_d  = WORD_RESET;                       // RL13
            zack_d = 1'b1;
        end else if (!zero_cmd) begin
            zack_d = 1'b0;                             // RL16
        end
        case (st_q)
            SV_IDLE: begin
                if (run_cmd && !zero_cmd) begin
                    tgt_d = pocr_clamp(target);        // RL11 RL12
                    ccw_d = pocr_clamp(target) > pos_q; // RL17
                    st_d  = (pocr_clamp(target) == pos_q) ? SV_DONE : SV_MOVE; // RL14
                end
            end
            SV_MOVE: begin
                if (tick)
                    pos_d = ccw_q ? pos_q + 16'sh0001 : pos_q - 16'sh0001;
                if (pos_d == tgt_q)
                    st_d = SV_DONE;                    // RL15
            end
            SV_DONE: begin
                if (!run_cmd)
                    st_d = SV_IDLE;                    // RL15
            end
            default: st_d = SV_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q   <= SV_IDLE;
            pos_q  <= WORD_RESET;
            tgt_q  <= WORD_RESET;
            zack_q <= 1'b0;
            ccw_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            pos_q  <= pos_d;
            tgt_q  <= tgt_d;
            zack_q <= zack_d;
            ccw_q  <= ccw_d;
        end
    end

    // status flags and count, one driver for the whole struct
    assign stat = '{ready: (st_q == SV_DONE), zero_ack: zack_q,
                    moving: (st_q == SV_MOVE), dir_ccw: ccw_q};
    assign pos  = pos_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_done_clears: assert property ((st_q == SV_DONE) && !run_cmd |=> !stat.ready) // RL15
        else $error("done flag kept after run dropped");
    a_zero_loads: assert property (zero_cmd && st_q != SV_MOVE |=> pos_q == 16'sh0000 && zack_q) // RL13
        else $error("zero command did not clear count");
    a_dir_sense: assert property (st_q == SV_IDLE && run_cmd && !zero_cmd // RL17
                                  && pocr_clamp(target) > pos_q |=> ccw_q)
        else $error("positive move not counter-clockwise");
    a_move_step: assert property (stat.moving && tick && !ccw_q |=> pos_q == $past(pos_q) - 16'sh0001) // RL12
        else $error("clockwise step wrong");
endmodule

// File: bench/pocr_plc_model.sv
`timescale 1ns/1ns
module pocr_plc_model (
    // clock
    input  wire logic                    mclk,
    // register port toward the device
    output logic                         wr_en,
    output logic [11:0]                  wr_addr,
    output logic [15:0]                  wr_data,
    output logic                         rd_en,
    output logic [11:0]                  rd_addr,
    input  wire logic [15:0]             rd_data,
    // servo status words
    input  wire pocr_pkg::pocr_sv_stat_t left_stat,
    input  wire pocr_pkg::pocr_sv_stat_t right_stat
);
    import pocr_pkg::*;

    // idle port values; lines flip after release so stale words never look valid
    initial begin
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        wr_addr = 12'hA5A;
        wr_data = 16'h5A5A;
        rd_addr = 12'h5A5;
    end

    // one word write taken at the next edge, then one idle cycle
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        wr_en   = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge mclk);
        #5;
        wr_en   = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
        @(posedge mclk);
        #5;
    endtask

    // one word read, sampled after the registered return has landed
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        rd_en   = 1'b1;
        rd_addr = a;
        @(posedge mclk);
        #5;
        rd_en   = 1'b0;
        rd_addr = ~a;
        @(posedge mclk);
        #5;
        d = rd_data;
    endtask

    // keep the command bit up until the flag answers, bounded, then drop it
    task automatic hold_until(input int m, input bit rdy, input int lim, output bit ok);
        pocr_sv_stat_t s;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            s  = m ? right_stat : left_stat;
            ok = rdy ? (s.ready === 1'b1) : (s.zero_ack === 1'b1);
            if (!ok) begin
                @(posedge mclk);
                #5;
            end
        end
        wr(m ? ADDR_R_COMMAND : ADDR_L_COMMAND, 16'h0000);
    endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import pocr_pkg::*;

    logic               mclk, rst_n, wr_en, rd_en, plc_mode, autocfg_load;
    logic [11:0]        wr_addr, rd_addr;
    logic [15:0]        wr_data, rd_data, autocfg_mask, us_status;
    logic [3:0]         sense_pins, sense_logic, sense_led_green;
    logic               ds_wake, ds_carton_exit, us_stb, us_accumulate, us_release;
    logic [1:0]         motor_tick = 2'b00;
    logic [1:0]         tick_sel;
    logic               tick_go;
    pocr_ds_msg_t       ds_msg;
    pocr_sv_stat_t      left_stat, right_stat;
    logic signed [15:0] left_pos, right_pos;
    logic [50:0]        ev_q[$];
    int                 model[10];
    int                 mpos[2];
    int                 ds_c[3] = '{4, 1, 7};
    int                 us_c[3] = '{5, 1, 7};
    int                 fails, checks_done, seed;
    int                 cyc = 0;

    pocr_regs pocr_regs_i (
        .mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .plc_mode(plc_mode),
        .autocfg_load(autocfg_load), .autocfg_mask(autocfg_mask), .sense_pins(sense_pins),
        .sense_logic(sense_logic), .sense_led_green(sense_led_green), .ds_msg(ds_msg),
        .ds_wake(ds_wake), .ds_carton_exit(ds_carton_exit), .us_stb(us_stb),
        .us_status(us_status), .us_accumulate(us_accumulate), .us_release(us_release),
        .motor_tick(motor_tick), .left_stat(left_stat), .right_stat(right_stat),
        .left_pos(left_pos), .right_pos(right_pos));

    pocr_plc_model pocr_plc_model_i (
        .mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .left_stat(left_stat), .right_stat(right_stat));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // record every link strobe with the words it carries
    always @(posedge mclk) begin
        if (ds_msg.stb === 1'b1)
            ev_q.push_back({1'b0, ds_wake, ds_carton_exit, ds_msg.status,
                            ds_msg.track_one, ds_msg.track_two});
        if (us_stb === 1'b1)
            ev_q.push_back({1'b1, 32'h0, us_accumulate, us_release, us_status});
    end

    // motor feedback: a level change every third cycle on the selected motor
    always @(posedge mclk) begin
        #5;
        cyc = cyc + 1;
        if (tick_go && cyc % 3 == 0)
            motor_tick = motor_tick ^ tick_sel;
    end

    task automatic summarize();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        checks_done++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    // expected register image, keeping only the bits each word holds
    function automatic void mwr(int a, int d);
        int i = a - 'h719;
        if (i >= 0 && i < 10 && i != 5)
            model[i] = d & (i == 2 ? 16'h0055 : (i == 7 || i == 9) ? 16'h0003 : 16'hFFFF);
    endfunction

    function automatic int mrd(int a);
        int i = a - 'h719;
        return (i >= 0 && i < 10) ? model[i] : 0;
    endfunction

    task automatic w(input int a, input int d);
        mwr(a, d);
        pocr_plc_model_i.wr(a[11:0], d[15:0]);
    endtask

    task automatic r(input int a);
        logic [15:0] v;
        pocr_plc_model_i.rd(a[11:0], v);
        chk("read word", mrd(a), v);
    endtask

    // status write and the single link message it must produce
    task automatic send(input bit up, input int c);
        logic [50:0] ex;
        ev_q.delete();
        w(up ? 'h71A : 'h719, c);
        repeat (3) @(posedge mclk);
        #5;
        ex = up ? {1'b1, 32'h0, c == 5, c == 1, c[15:0]}
                : {1'b0, c == 4, c == 1, c[15:0], model[3][15:0], model[4][15:0]};
        chk("link count", 1, ev_q.size());
        if (ev_q.size() == 1)
            chk("link value", ex, ev_q[0]);
    endtask

    // conditioned inputs and indicators after pins and mask settle
    task automatic chk_in();
        logic [3:0] ex;
        ex = sense_pins ^ {model[2][6], model[2][4], model[2][2], model[2][0]};
        repeat (4) @(posedge mclk);
        #5;
        chk("sense", ex, sense_logic);
        chk("led", ex, sense_led_green);
    endtask

    task automatic move(input int m, input int tg);
        pocr_sv_stat_t st;
        bit            ok;
        int            ca;
        ca = m ? 'h722 : 'h720;
        w(ca - 1, tg);
        w(ca, 2);
        @(posedge mclk);
        #5;
        st = m ? right_stat : left_stat;
        if (tg != mpos[m])
            chk("move dir", {1'b1, tg > mpos[m]}, {st.moving, st.dir_ccw});
        tick_sel = m ? 2'b10 : 2'b01;
        tick_go  = 1'b1;
        pocr_plc_model_i.hold_until(m, 1'b1, 600, ok);
        mwr(ca, 0);
        repeat (6) @(posedge mclk);
        #5;
        st = m ? right_stat : left_stat;
        chk("move end", {2'b10, tg[15:0]}, {ok, st.ready, m ? right_pos : left_pos});
        tick_go = 1'b0;
        mpos[m] = tg;
    endtask

    task automatic zero(input int m);
        bit ok;
        w(m ? 'h722 : 'h720, 1);
        pocr_plc_model_i.hold_until(m, 1'b0, 20, ok);
        mwr(m ? 'h722 : 'h720, 0);
        repeat (3) @(posedge mclk);
        #5;
        chk("zero", {1'b1, 16'h0000}, {ok, m ? right_pos : left_pos});
        mpos[m] = 0;
    endtask

    // watchdog
    initial begin
        #(50 * 20000);
        fails++;
        summarize();
    end

    // main sequence
    initial begin
        seed         = 32'h51BD;
        rst_n        = 1'b0;
        plc_mode     = 1'b0;
        autocfg_load = 1'b0;
        autocfg_mask = 16'h0000;
        sense_pins   = 4'h0;
        tick_go      = 1'b0;
        tick_sel     = 2'b00;
        repeat (4) @(posedge mclk);
        #5;
        rst_n = 1'b1;
        for (int a = 'h718; a <= 'h723; a++)
            r(a);
        autocfg_mask = 16'h0055;
        autocfg_load = 1'b1;
        @(posedge mclk);
        #5;
        autocfg_load = 1'b0;
        model[2] = 'h55;
        chk_in();
        plc_mode = 1'b1;
        model[2] = 0;
        chk_in();
        r('h71B);
        autocfg_load = 1'b1;
        @(posedge mclk);
        #5;
        autocfg_load = 1'b0;
        chk_in();
        repeat (8) begin
            w('h71B, $random(seed));
            sense_pins = $random(seed);
            chk_in();
        end
        for (int a = 'h718; a <= 'h723; a++)
            w(a, (a == 'h720 || a == 'h722) ? $random(seed) & 16'hFFFC : $random(seed));
        for (int a = 'h718; a <= 'h723; a++)
            r(a);
        ev_q.delete();
        w('h71C, $random(seed));
        w('h71D, $random(seed));
        chk("quiet tracking", 0, ev_q.size());
        for (int i = 0; i < 3; i++) begin
            send(1'b0, ds_c[i]);
            send(1'b1, us_c[i]);
        end
        for (int m = 0; m < 2; m++) begin
            move(m, 3);
            move(m, -2);
            move(m, -2);
            move(m, $random(seed) % 7);
            zero(m);
            move(m, 1);
        end
        summarize();
    end
endmodule
